//--- sivl_consts.svh
/*
  Constants of the system interrupt, vector and low-power block:
  register offsets, bit positions, reset values, vector slots, memory map.
  Assumes inclusion by bare name from the package and the core.
*/
`ifndef SIVL_CONSTS_SVH
`define SIVL_CONSTS_SVH

`define SIVL_OFS_EN_LO     8'h00
`define SIVL_OFS_EN_HI     8'h01
`define SIVL_OFS_FLG_LO    8'h02
`define SIVL_OFS_FLG_HI    8'h03

`define SIVL_BIT_WDT       0
`define SIVL_BIT_OSC       1
`define SIVL_BIT_POR       2
`define SIVL_BIT_RST       3
`define SIVL_BIT_NMI       4
`define SIVL_BIT_ACCV      5

`define SIVL_EN_MASK       8'h33
`define SIVL_FLG_MASK      8'h1F
`define SIVL_EN_RST        8'h00

`define SIVL_VEC_BASE      16'hFFC0
`define SIVL_VEC_ERASED    16'hFFFF
`define SIVL_PRIO_RESET    5'h1F
`define SIVL_PRIO_NMI      5'h1E
`define SIVL_PRIO_WDT      5'h1A
`define SIVL_PRIO_CC0      5'h19
`define SIVL_PRIO_CC1      5'h18
`define SIVL_PRIO_CONV     5'h15
`define SIVL_PRIO_SER      5'h14
`define SIVL_PRIO_P2       5'h13
`define SIVL_PRIO_P1       5'h12
`define SIVL_PRIO_MIN_USED 5'h10

`define SIVL_PERIPH_TOP    16'h01FF
`define SIVL_RAM_LO        16'h0200
`define SIVL_RAM_HI        16'h027F
`define SIVL_INFO_LO       16'h1000
`define SIVL_INFO_HI       16'h10FF
`define SIVL_CODE_LO       16'hF800

`endif

//--- sivl_pkg.sv
/*
  Types of the system interrupt, vector and low-power block.
  Assumes sivl_consts.svh in the include path.
*/
`default_nettype none
package sivl_pkg;
  `include "sivl_consts.svh"

  typedef enum logic [2:0] {
    run_state,
    sleep_level_a,
    sleep_level_b,
    sleep_level_c,
    sleep_level_d,
    sleep_level_e
  } sivl_mode_e;

  typedef struct packed {
    logic cpu_en;
    logic main_clk_en;
    logic sub_main_clk_en;
    logic aux_clk_en;
    logic digital_osc_gen_en;
    logic xtal_en;
  } sivl_clk_s;

  typedef struct packed {
    logic       capture_compare_flag0;
    logic       capture_compare_flag1;
    logic       timer_overflow_flag;
    logic       converter_done_flag;
    logic       converter_overflow_flag;
    logic       serial_if_flag;
    logic       serial_start_flag;
    logic [1:0] port_two_edge_flags;
    logic [7:0] port_one_edge_flags;
  } sivl_periph_s;
endpackage
`default_nettype wire

//--- sivl_core.sv
/*
  System interrupt vector, reset source and low-power mode controller.
  Assumes one 25 MHz clock, peripheral flags and cpu strobes on that clock,
  and the reset/nmi pin and oscillator fault arriving asynchronously.
*/
// The strobed register port was left to the implementer.
// What this block does
// - power-up, pin reset, watchdog, key violation, bad fetch all use reset vector 31
// - nmi pin, oscillator fault, flash access violation share vector 30
// - nmi group gated only by own enables, never by global enable
// - timer cc1 and overflow share vector 24; cc0 owns vector 25
// - eight port one edge flags share vector 18
// - port two bits 6 and 7 share vector 19
// - maskable peripheral flags stay inside their modules
// - slots 15 down to 0 carry no source
// - vectors fill the top 64 bytes; higher address means higher priority
// - each vector entry is one 16-bit handler address word
// - erased reset vector sends device to deepest sleep after power-up
// - fetch from peripheral space or unused space causes system reset
// - enabled interrupt wakes from any sleep; return restores the sleep
// - active runs all clocks; level a stops cpu and main clock
// - level b also stops oscillator generator when not sourcing clocks
// - level c stops cpu, main and sub-main, keeps generator and aux
// - level d leaves only the auxiliary clock running
// - level e stops aux clock and crystal too
// - unassigned register bits read zero and ignore writes
// - plain-default bits reset on every clear; bracketed only on power-on
// - watchdog enable acts only in interval timer mode
// - pin reset, power-on and oscillator fault flags set by their events
`default_nettype none
`include "sivl_consts.svh"
module sivl_core (
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic [7:0]                reg_rdata_o,
  input  wire logic                 rst_nmi_pin_n_i,
  input  wire logic                 pin_nmi_mode_i,
  input  wire logic                 osc_fault_i,
  input  wire logic                 watchdog_expire_i,
  input  wire logic                 watchdog_interval_mode_i,
  input  wire logic                 flash_key_violation_i,
  input  wire logic                 flash_access_violation_flag_i,
  input  wire sivl_pkg::sivl_periph_s periph_flags_i,
  input  wire logic                 gie_i,
  input  wire logic [15:0]          fetch_addr_i,
  input  wire logic                 fetch_valid_i,
  input  wire logic [15:0]          reset_vector_word_i,
  input  wire logic                 irq_ack_i,
  input  wire logic                 reti_i,
  input  wire logic                 sleep_req_i,
  input  wire sivl_pkg::sivl_mode_e sleep_level_i,
  input  wire logic                 digital_osc_sources_active_i,
  output logic                      irq_req_o,
  output logic [15:0]               irq_vec_addr_o,
  output logic [4:0]                irq_prio_o,
  output logic                      power_up_clear_o,
  output sivl_pkg::sivl_mode_e      op_mode_o,
  output sivl_pkg::sivl_clk_s       clk_ctl_o
);
  import sivl_pkg::*;

  logic [7:0]  en_r;
  logic [7:0]  flg_r;
  logic [2:0]  pin_sync_r;
  logic [1:0]  osc_sync_r;
  logic        power_up_clear_r;
  logic        boot_chk_r;
  sivl_mode_e  mode_r;
  sivl_mode_e  saved_mode_r;
  logic [31:0] req_vec;
  logic        any_req;
  logic [4:0]  top_prio;
  logic        pin_fall;
  logic        pin_rst_evt;
  logic        pin_nmi_evt;
  logic        wdt_rst_evt;
  logic        bad_fetch;
  logic        power_up_clear_nxt;
  logic        clear_all;
  logic        wr_en;
  logic        wr_flg;
  logic        nmi_req;

  // pin and oscillator fault synchronisers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pin_sync_r <= 3'h7;
      osc_sync_r <= 2'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], rst_nmi_pin_n_i};
      osc_sync_r <= {osc_sync_r[0], osc_fault_i};
    end
  end

  assign pin_fall    = pin_sync_r[2] & ~pin_sync_r[1];
  assign pin_rst_evt = pin_fall & ~pin_nmi_mode_i;
  assign pin_nmi_evt = pin_fall & pin_nmi_mode_i;
  assign wdt_rst_evt = watchdog_expire_i & ~watchdog_interval_mode_i;

  // fetch outside ram, info and code space
  assign bad_fetch = fetch_valid_i &
                     (fetch_addr_i <= `SIVL_PERIPH_TOP |
                      ~((fetch_addr_i >= `SIVL_RAM_LO & fetch_addr_i <= `SIVL_RAM_HI) |
                        (fetch_addr_i >= `SIVL_INFO_LO & fetch_addr_i <= `SIVL_INFO_HI) |
                        fetch_addr_i >= `SIVL_CODE_LO));

  assign power_up_clear_nxt = pin_rst_evt | wdt_rst_evt |
                              flash_key_violation_i | bad_fetch;
  assign clear_all = reset_i | power_up_clear_r;
  assign wr_en     = reg_wr_i & (reg_addr_i == `SIVL_OFS_EN_LO);
  assign wr_flg    = reg_wr_i & (reg_addr_i == `SIVL_OFS_FLG_LO);

  // power-up clear pulse
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      power_up_clear_r <= 1'b0;
      power_up_clear_o <= 1'b0;
    end else begin
      power_up_clear_r <= power_up_clear_nxt;
      power_up_clear_o <= power_up_clear_nxt;
    end
  end

  // enable byte: all bits reset on every clear
  always_ff @(posedge core_clk_i) begin
    if (clear_all) begin
      en_r <= `SIVL_EN_RST;
    end else if (wr_en) begin
      en_r <= reg_wdata_i & `SIVL_EN_MASK;
    end
  end

  // flag byte: hardware set beats software clear
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      flg_r <= 8'h00;
      flg_r[`SIVL_BIT_POR] <= 1'b1;
      flg_r[`SIVL_BIT_OSC] <= 1'b1;
    end else begin
      if (wr_flg) begin
        flg_r <= reg_wdata_i & `SIVL_FLG_MASK;
      end
      if (power_up_clear_r) begin
        flg_r[`SIVL_BIT_NMI] <= 1'b0;
        flg_r[`SIVL_BIT_OSC] <= 1'b1;
      end
      if (pin_nmi_evt) begin
        flg_r[`SIVL_BIT_NMI] <= 1'b1;
      end
      if (osc_sync_r[1]) begin
        flg_r[`SIVL_BIT_OSC] <= 1'b1;
      end
      if (pin_rst_evt) begin
        flg_r[`SIVL_BIT_RST] <= 1'b1;
      end
      if (watchdog_expire_i) begin
        flg_r[`SIVL_BIT_WDT] <= 1'b1;
      end
    end
  end

  // register read, one cycle later
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `SIVL_OFS_EN_LO) begin
        reg_rdata_o <= en_r;
      end else if (reg_addr_i == `SIVL_OFS_FLG_LO) begin
        reg_rdata_o <= flg_r;
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // request map, peripheral flags held in their modules
  assign nmi_req = (flg_r[`SIVL_BIT_NMI] & en_r[`SIVL_BIT_NMI]) |
                   (flg_r[`SIVL_BIT_OSC] & en_r[`SIVL_BIT_OSC]) |
                   (flash_access_violation_flag_i & en_r[`SIVL_BIT_ACCV]);

  always_comb begin
    req_vec = 32'h0000_0000;
    req_vec[`SIVL_PRIO_NMI] = nmi_req;
    req_vec[`SIVL_PRIO_WDT] = gie_i & watchdog_interval_mode_i &
                              flg_r[`SIVL_BIT_WDT] & en_r[`SIVL_BIT_WDT];
    req_vec[`SIVL_PRIO_CC0] = gie_i & periph_flags_i.capture_compare_flag0;
    req_vec[`SIVL_PRIO_CC1] = gie_i & (periph_flags_i.capture_compare_flag1 |
                                       periph_flags_i.timer_overflow_flag);
    req_vec[`SIVL_PRIO_CONV] = gie_i & (periph_flags_i.converter_done_flag |
                                        periph_flags_i.converter_overflow_flag);
    req_vec[`SIVL_PRIO_SER] = gie_i & (periph_flags_i.serial_if_flag |
                                       periph_flags_i.serial_start_flag);
    req_vec[`SIVL_PRIO_P2] = gie_i & (|periph_flags_i.port_two_edge_flags);
    req_vec[`SIVL_PRIO_P1] = gie_i & (|periph_flags_i.port_one_edge_flags);
  end

  // highest set slot wins
  always_comb begin
    top_prio = 5'h00;
    any_req  = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (req_vec[i]) begin
        top_prio = 5'(i);
        any_req  = 1'b1;
      end
    end
  end

  // vector request to cpu
  always_ff @(posedge core_clk_i) begin
    if (clear_all) begin
      irq_req_o      <= 1'b0;
      irq_prio_o     <= `SIVL_PRIO_RESET;
      irq_vec_addr_o <= `SIVL_VEC_BASE + {10'h000, `SIVL_PRIO_RESET, 1'b0};
    end else begin
      irq_req_o <= any_req & ~irq_ack_i;
      if (any_req) begin
        irq_prio_o     <= top_prio;
        irq_vec_addr_o <= `SIVL_VEC_BASE + {10'h000, top_prio, 1'b0};
      end
    end
  end

  // erased reset vector check after power-up
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      boot_chk_r <= 1'b1;
    end else begin
      boot_chk_r <= 1'b0;
    end
  end

  // operating mode with wake and restore
  always_ff @(posedge core_clk_i) begin
    if (clear_all) begin
      mode_r       <= run_state;
      saved_mode_r <= run_state;
    end else if (boot_chk_r & (reset_vector_word_i == `SIVL_VEC_ERASED)) begin
      mode_r <= sleep_level_e;
    end else if (any_req & mode_r != run_state) begin
      saved_mode_r <= mode_r;
      mode_r       <= run_state;
    end else if (reti_i) begin
      mode_r       <= saved_mode_r;
      saved_mode_r <= run_state;
    end else if (sleep_req_i) begin
      mode_r <= sleep_level_i;
    end
  end

  // clock gating per mode
  always_ff @(posedge core_clk_i) begin
    if (clear_all) begin
      op_mode_o <= run_state;
      clk_ctl_o <= 6'h3F;
    end else begin
      op_mode_o <= mode_r;
      case (mode_r)
        run_state: begin
          clk_ctl_o <= 6'h3F;
        end
        sleep_level_a: begin
          clk_ctl_o <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        end
        sleep_level_b: begin
          clk_ctl_o <= '{1'b0, 1'b0, 1'b1, 1'b1,
                         digital_osc_sources_active_i, 1'b1};
        end
        sleep_level_c: begin
          clk_ctl_o <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        end
        sleep_level_d: begin
          clk_ctl_o <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        end
        default: begin
          clk_ctl_o <= 6'h00;
        end
      endcase
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  a_nmi_no_gie: assert property (
    (flg_r[`SIVL_BIT_NMI] & en_r[`SIVL_BIT_NMI] & ~gie_i & ~irq_ack_i & ~power_up_clear_r)
      |=> irq_req_o & irq_prio_o >= `SIVL_PRIO_NMI)
    else $error("nmi request blocked by global enable");

  a_vec_addr_map: assert property (
    irq_req_o |-> irq_vec_addr_o == (`SIVL_VEC_BASE + {10'h000, irq_prio_o, 1'b0}))
    else $error("vector address does not match priority");

  a_low_slots_idle: assert property (
    irq_req_o |-> irq_prio_o >= `SIVL_PRIO_MIN_USED)
    else $error("request in unused slot");

  a_bad_fetch_reset: assert property (
    (fetch_valid_i & fetch_addr_i <= `SIVL_PERIPH_TOP)
      |=> power_up_clear_o ##1 mode_r == run_state)
    else $error("peripheral fetch did not reset");

  a_pin_nmi_flag: assert property (
    (pin_nmi_evt & ~power_up_clear_r) |=> flg_r[`SIVL_BIT_NMI])
    else $error("nmi pin event lost");

  a_wdt_gate: assert property (
    ~watchdog_interval_mode_i |=> ~(irq_req_o & (irq_prio_o == `SIVL_PRIO_WDT)))
    else $error("watchdog vector in reset mode");

  a_wake_restore: assert property (
    (any_req & mode_r != run_state & ~clear_all & ~boot_chk_r)
      |=> mode_r == run_state & saved_mode_r == $past(mode_r))
    else $error("wake did not save sleep level");

  a_deep_sleep_off: assert property (
    (mode_r == sleep_level_e & ~clear_all) |=> clk_ctl_o == 6'h00)
    else $error("clocks running in deepest sleep");

  a_level_d_aux: assert property (
    (mode_r == sleep_level_d & ~clear_all) |=> clk_ctl_o == 6'h05)
    else $error("level d clock set wrong");

  a_por_flag_keep: assert property (
    (power_up_clear_r & ~wr_flg) |=> $stable(flg_r[`SIVL_BIT_POR]))
    else $error("power-on flag changed by clear");

  a_prio_order: assert property (
    (req_vec[`SIVL_PRIO_P1] & req_vec[`SIVL_PRIO_CC0] & ~irq_ack_i & ~clear_all)
      |=> irq_prio_o >= `SIVL_PRIO_CC0)
    else $error("lower priority served first");

  c_nmi_taken: cover property (irq_req_o & irq_prio_o == `SIVL_PRIO_NMI & irq_ack_i);
  c_sleep_wake: cover property (mode_r == sleep_level_d ##1 mode_r == run_state);
  c_pin_reset: cover property (pin_rst_evt ##1 power_up_clear_o);
endmodule
`default_nettype wire

//--- sivl_cpu_model.sv
/*
  Partner model of the cpu side: takes vectors after a set delay and
  drives the reset/nmi pin on request of the bench.
  Assumes the core clock and synchronous reset of sivl_core.
*/
`default_nettype none
module sivl_cpu_model #(
  parameter int ACK_DLY = 2
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        irq_req_i,
  input  wire logic [4:0]  irq_prio_i,
  input  wire logic [15:0] irq_vec_i,
  input  wire logic        ack_en_i,
  input  wire logic        pin_hold_i,
  output logic             irq_ack_o,
  output logic             rst_nmi_pin_n_o,
  output logic [7:0]       taken_o,
  output logic [4:0]       last_prio_o,
  output logic [15:0]      last_vec_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_r;

  // one-cycle acknowledge once a request has stood ACK_DLY cycles
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_ack_o   <= 1'b0;
      wait_r      <= 0;
      taken_o     <= 8'h00;
      last_prio_o <= 5'h00;
      last_vec_o  <= 16'h0000;
    end else if (irq_ack_o) begin
      irq_ack_o <= 1'b0;
      wait_r    <= 0;
    end else if (!irq_req_i) begin
      wait_r <= 0;
    end else if (ack_en_i && wait_r >= ACK_DLY) begin
      irq_ack_o   <= 1'b1;
      taken_o     <= taken_o + 8'h01;
      last_prio_o <= irq_prio_i;
      last_vec_o  <= irq_vec_i;
    end else begin
      wait_r <= wait_r + 1;
    end
  end

  // pin held low while asked, high otherwise
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rst_nmi_pin_n_o <= 1'b1;
    end else begin
      rst_nmi_pin_n_o <= !pin_hold_i;
    end
  end
endmodule
`default_nettype wire

//--- sivl_core_tb.sv
/*
  Self-checking bench of sivl_core: register port, vectors, reset sources
  and sleep modes. Assumes sivl_pkg and sivl_cpu_model compiled before it.
*/
`default_nettype none
module sivl_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sivl_pkg::*;

  logic         core_clk_i = 1'b0;
  logic         reset_i = 1'b1;
  logic         reg_wr_i = 1'b0, reg_rd_i = 1'b0, pin_nmi_mode_i = 1'b0, osc_fault_i = 1'b0;
  logic         watchdog_expire_i = 1'b0, watchdog_interval_mode_i = 1'b0, gie_i = 1'b0;
  logic         flash_key_violation_i = 1'b0, flash_access_violation_flag_i = 1'b0;
  logic         fetch_valid_i = 1'b0, reti_i = 1'b0, sleep_req_i = 1'b0;
  logic         digital_osc_sources_active_i = 1'b0, ack_en = 1'b0, pin_hold = 1'b0;
  logic [7:0]   reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, taken;
  logic [15:0]  fetch_addr_i = 16'hF800, reset_vector_word_i = 16'hFFFF;
  logic [15:0]  irq_vec_addr_o, last_vec;
  logic [4:0]   irq_prio_o, last_prio;
  logic         rst_nmi_pin_n_i, irq_ack_i, irq_req_o, power_up_clear_o;
  sivl_periph_s periph_flags_i = '0;
  sivl_mode_e   sleep_level_i = run_state;
  sivl_mode_e   op_mode_o;
  sivl_clk_s    clk_ctl_o;
  int           n_mismatch = 0;
  int           check_count = 0;

  logic [7:0]   ra [7] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h02, 8'h03, 8'h7F};
  logic [7:0]   rw [7] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF};
  logic [7:0]   rx [7] = '{8'h33, 8'h00, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h00};
  sivl_periph_s pv [11] = '{17'h10000, 17'h08000, 17'h04000, 17'h02000, 17'h01000,
                            17'h00800, 17'h00400, 17'h00200, 17'h00100, 17'h00080, 17'h00001};
  logic [4:0]   pp [11] = '{5'h19, 5'h18, 5'h18, 5'h15, 5'h15, 5'h14, 5'h14,
                            5'h13, 5'h13, 5'h12, 5'h12};
  logic [7:0]   ne [3] = '{8'h02, 8'h10, 8'h20};
  logic [7:0]   nf [3] = '{8'h02, 8'h10, 8'h00};
  logic [15:0]  fa [4] = '{16'h0100, 16'h1100, 16'hF800, 16'h0200};
  logic         fe [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  sivl_mode_e   sl [6] = '{sleep_level_a, sleep_level_b, sleep_level_b, sleep_level_c,
                           sleep_level_d, sleep_level_e};
  logic [5:0]   sx [6] = '{6'h0F, 6'h0D, 6'h0F, 6'h07, 6'h05, 6'h00};

  always #20 core_clk_i = ~core_clk_i;

  sivl_core u_dut (.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .rst_nmi_pin_n_i, .pin_nmi_mode_i, .osc_fault_i, .watchdog_expire_i,
    .watchdog_interval_mode_i, .flash_key_violation_i, .flash_access_violation_flag_i,
    .periph_flags_i, .gie_i, .fetch_addr_i, .fetch_valid_i, .reset_vector_word_i,
    .irq_ack_i, .reti_i, .sleep_req_i, .sleep_level_i, .digital_osc_sources_active_i,
    .irq_req_o, .irq_vec_addr_o, .irq_prio_o, .power_up_clear_o, .op_mode_o, .clk_ctl_o);

  sivl_cpu_model #(.ACK_DLY(2)) u_cpu (.core_clk_i, .reset_i, .irq_req_i(irq_req_o),
    .irq_prio_i(irq_prio_o), .irq_vec_i(irq_vec_addr_o), .ack_en_i(ack_en),
    .pin_hold_i(pin_hold), .irq_ack_o(irq_ack_i), .rst_nmi_pin_n_o(rst_nmi_pin_n_i),
    .taken_o(taken), .last_prio_o(last_prio), .last_vec_o(last_vec));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic give_up();
    n_mismatch++;
    results();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(what, 16'(reg_rdata_o), 16'(exp));
  endtask

  // one-cycle pulse: 0 fetch, 1 key, 2 watchdog, 3 return, 4 sleep
  task automatic strobe(input int i);
    @(posedge core_clk_i);
    fetch_valid_i         <= (i == 0);
    flash_key_violation_i <= (i == 1);
    watchdog_expire_i     <= (i == 2);
    reti_i                <= (i == 3);
    sleep_req_i           <= (i == 4);
    @(posedge core_clk_i);
    fetch_valid_i         <= 1'b0;
    flash_key_violation_i <= 1'b0;
    watchdog_expire_i     <= 1'b0;
    reti_i                <= 1'b0;
    sleep_req_i           <= 1'b0;
  endtask

  task automatic want_irq(input logic [4:0] prio);
    int k;
    k = 0;
    #1;
    while (irq_req_o !== 1'b1) begin
      @(posedge core_clk_i);
      #1 k++;
      if (k > 12) give_up();
    end
    chk("prio", 16'(irq_prio_o), 16'(prio));
    chk("vector", irq_vec_addr_o, 16'hFFC0 + {10'h000, prio, 1'b0});
  endtask

  task automatic want_clear(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      #1 seen = seen | power_up_clear_o;
      @(posedge core_clk_i);
    end
    chk("power-up clear", 16'(seen), 16'(exp));
  endtask

  task automatic wait_taken(input logic [7:0] n);
    int k;
    k = 0;
    #1;
    while (taken !== n) begin
      @(posedge core_clk_i);
      #1 k++;
      if (k > 20) give_up();
    end
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    give_up();
  end

  initial begin
    cyc(3);
    reset_i <= 1'b0;
    cyc(4);
    #1 chk("erased mode", 16'(op_mode_o), 16'(sleep_level_e));
    chk("erased clocks", 16'(clk_ctl_o), 16'h0000);
    @(posedge core_clk_i);
    reset_i             <= 1'b1;
    reset_vector_word_i <= 16'hF800;
    cyc(3);
    reset_i <= 1'b0;
    cyc(2);
    #1 chk("run clocks", 16'(clk_ctl_o), 16'h003F);
    rd(8'h00, 8'h00, "enable reset");
    rd(8'h02, 8'h06, "flag reset");
    for (int i = 0; i < 7; i++) begin
      wr(ra[i], rw[i]);
      rd(ra[i], rx[i], "register");
    end
    $display("test reset and registers done");
    for (int i = 0; i < 11; i++) begin
      @(posedge core_clk_i);
      periph_flags_i <= pv[i];
      gie_i          <= 1'b0;
      cyc(3);
      #1 chk("masked", 16'(irq_req_o), 16'h0000);
      @(posedge core_clk_i);
      gie_i <= 1'b1;
      want_irq(pp[i]);
      @(posedge core_clk_i);
      periph_flags_i <= '0;
    end
    @(posedge core_clk_i);
    ack_en         <= 1'b1;
    periph_flags_i <= 17'h10001;
    wait_taken(8'h01);
    @(posedge core_clk_i);
    periph_flags_i <= 17'h00001;
    #1 chk("first taken", 16'(last_prio), 16'h0019);
    wait_taken(8'h02);
    chk("second taken", last_vec, 16'hFFE4);
    @(posedge core_clk_i);
    ack_en         <= 1'b0;
    periph_flags_i <= '0;
    $display("test maskable vectors done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h02, 8'h00);
      wr(8'h00, ne[i]);
      @(posedge core_clk_i);
      gie_i                         <= 1'b0;
      pin_nmi_mode_i                <= 1'b1;
      osc_fault_i                   <= (i == 0);
      pin_hold                      <= (i == 1);
      flash_access_violation_flag_i <= (i == 2);
      want_irq(5'h1E);
      rd(8'h02, nf[i], "nmi flags");
      @(posedge core_clk_i);
      osc_fault_i                   <= 1'b0;
      pin_hold                      <= 1'b0;
      flash_access_violation_flag_i <= 1'b0;
      wr(8'h00, 8'h00);
      cyc(3);
      #1 chk("nmi blocked", 16'(irq_req_o), 16'h0000);
    end
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h01);
    @(posedge core_clk_i);
    watchdog_interval_mode_i <= 1'b1;
    gie_i                    <= 1'b1;
    strobe(2);
    want_irq(5'h1A);
    wr(8'h02, 8'h00);
    $display("test nmi and watchdog done");
    @(posedge core_clk_i);
    watchdog_interval_mode_i <= 1'b0;
    pin_nmi_mode_i           <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      fetch_addr_i <= fa[i];
      strobe(0);
      want_clear(fe[i]);
    end
    strobe(1);
    want_clear(1'b1);
    strobe(2);
    want_clear(1'b1);
    wr(8'h02, 8'h00);
    @(posedge core_clk_i);
    pin_hold <= 1'b1;
    want_clear(1'b1);
    @(posedge core_clk_i);
    pin_hold <= 1'b0;
    rd(8'h02, 8'h0A, "pin reset flags");
    $display("test reset sources done");
    @(posedge core_clk_i);
    fetch_addr_i <= 16'h0100;
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk_i);
      sleep_level_i                <= sl[i];
      digital_osc_sources_active_i <= (i == 2);
      strobe(4);
      cyc(2);
      #1 chk("sleep clocks", 16'(clk_ctl_o), 16'(sx[i]));
      chk("sleep mode", 16'(op_mode_o), 16'(sl[i]));
      strobe(0);
      want_clear(1'b1);
      #1 chk("back to run", 16'(clk_ctl_o), 16'h003F);
    end
    @(posedge core_clk_i);
    sleep_level_i <= sleep_level_d;
    strobe(4);
    cyc(2);
    @(posedge core_clk_i);
    periph_flags_i <= 17'h00080;
    want_irq(5'h12);
    cyc(3);
    #1 chk("woken clocks", 16'(clk_ctl_o), 16'h003F);
    @(posedge core_clk_i);
    periph_flags_i <= '0;
    cyc(2);
    strobe(3);
    cyc(2);
    #1 chk("restored clocks", 16'(clk_ctl_o), 16'h0005);
    chk("restored mode", 16'(op_mode_o), 16'(sleep_level_d));
    $display("test sleep modes done");
    results();
  end
endmodule
`default_nettype wire
